//--- meas_pkg.sv
// Constants, field positions, timing counts and helpers of the proximity measurement control.
// Assumes a single 10 MHz clock and a command-coded 16-bit register port.
package meas_pkg;

    // Command codes of the 16-bit register words
    localparam logic [7:0] CMD_CONFIG_A = 8'h03;
    localparam logic [7:0] CMD_CONFIG_B = 8'h04;
    localparam logic [7:0] CMD_OFFSET = 8'h07;
    localparam logic [7:0] CMD_RESULT = 8'h08;
    localparam logic [7:0] CMD_INT_FLAG = 8'hf5;

    // Widths
    localparam int WORD_W = 16;
    localparam int CMD_W = 8;
    localparam int COUNT_W = 12;
    localparam int OFFSET_W = 12;
    localparam int GAIN_W = 13;
    localparam int LUX_W = 8;
    localparam int SEL_W = 2;
    localparam int PULSE_CNT_W = 13;
    localparam int PERIOD_CNT_W = 24;

    // Field positions
    localparam int PULSE_SEL_LSB = 14;
    localparam int HIGH_GAIN_POS = 10;
    localparam int INTERVAL_LSB = 6;
    localparam int AMB_EN_POS = 15;
    localparam int AMB_LEVEL_LSB = 13;
    localparam int SAT_IRQ_POS = 2;
    localparam int SAT_FLAG_POS = 12;

    // Reset values
    localparam logic [WORD_W-1:0] CONFIG_A_RST = 16'h0000;
    localparam logic [WORD_W-1:0] CONFIG_B_RST = 16'h0000;
    localparam logic [OFFSET_W-1:0] OFFSET_RST = 12'h000;

    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_T_US = 50;
    localparam int PULSE_T_CYC = (PULSE_T_US * (CLK_HZ / 1_000_000));
    localparam int INTERVAL_BASE_MS = 10;
    localparam int INTERVAL_BASE_CYC = INTERVAL_BASE_MS * (CLK_HZ / 1000);

    // Saturation limits in klux
    localparam logic [LUX_W-1:0] LUX_NO_CANCEL = 8'h04;
    localparam logic [LUX_W-1:0] LUX_LEVEL1 = 8'h0c;
    localparam logic [LUX_W-1:0] LUX_LEVEL2 = 8'h18;
    localparam logic [LUX_W-1:0] LUX_LEVEL3 = 8'h2a;
    localparam logic [LUX_W-1:0] LUX_LEVEL4 = 8'h64;

    typedef enum {ST_IDLE, ST_AMBIENT, ST_PULSE, ST_CONVERT} meas_state_e;

    // Difference clamped at zero
    function automatic logic [GAIN_W-1:0] sat_sub(input logic [GAIN_W-1:0] a,
                                                  input logic [GAIN_W-1:0] b);
        return (a > b) ? (a - b) : '0;
    endfunction

    // Highest illuminance that the selected cancellation can handle
    function automatic logic [LUX_W-1:0] lux_limit(input logic en, input logic [SEL_W-1:0] lvl);
        if (!en)
            return LUX_NO_CANCEL;
        case (lvl)
            2'h0: return LUX_LEVEL1;
            2'h1: return LUX_LEVEL2;
            2'h2: return LUX_LEVEL3;
            default: return LUX_LEVEL4;
        endcase
    endfunction

endpackage

//--- meas_timer_if.sv
// Carrier between the measurement sequencer and its timer.
// Assumes both ends run on the same clock.
interface meas_timer_if;
    logic start;
    logic [meas_pkg::SEL_W-1:0] pulse_sel;
    logic [meas_pkg::SEL_W-1:0] interval_sel;
    logic period_tick;
    logic pulse_done;

    modport ctrl (output start, output pulse_sel, output interval_sel,
                  input period_tick, input pulse_done);
    modport timer (input start, input pulse_sel, input interval_sel,
                   output period_tick, output pulse_done);
endinterface

//--- meas_timer.sv
// Measurement interval divider and emitter pulse length counter.
// Assumes start is a one-cycle pulse from the sequencer.
module meas_timer
#(
    parameter int INTERVAL_CYC = meas_pkg::INTERVAL_BASE_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    meas_timer_if.timer tm
);
    import meas_pkg::*;

    logic [PERIOD_CNT_W-1:0] per_q;
    logic [PERIOD_CNT_W-1:0] per_d;
    logic [PERIOD_CNT_W-1:0] per_lim;
    logic [PULSE_CNT_W-1:0] pls_q;
    logic [PULSE_CNT_W-1:0] pls_d;
    logic run_q;
    logic run_d;

    // Interval limit doubles per code step
    assign per_lim = (PERIOD_CNT_W'(INTERVAL_CYC) << tm.interval_sel) - PERIOD_CNT_W'(1);
    assign tm.period_tick = (per_q >= per_lim);
    assign per_d = tm.period_tick ? '0 : per_q + PERIOD_CNT_W'(1);

    // Pulse lasts base unit times two to the code
    assign pls_d = tm.start ? (PULSE_CNT_W'(PULSE_T_CYC) << tm.pulse_sel) - PULSE_CNT_W'(1)
                 : (run_q && pls_q != '0) ? pls_q - PULSE_CNT_W'(1) : pls_q;
    assign run_d = tm.start ? 1'b1 : (run_q && pls_q != '0);
    assign tm.pulse_done = run_q && (pls_q == '0);

    // Counter registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            per_q <= '0;
            pls_q <= '0;
            run_q <= 1'b0;
        end
        else
        begin
            per_q <= per_d;
            pls_q <= pls_d;
            run_q <= run_d;
        end
    end
endmodule

//--- proximity_measure_control.sv
// Proximity measurement control: pulse timing, gain, offset and ambient handling,
// saturation protection with a read-cleared flag and an active-low interrupt.
// Assumes a decoded command port from the serial interface and synchronous sensor inputs.

// Operation
// - Emitter pulse is multiple of 50 us
// - Bits 15:14 select 1T 2T 4T 8T
// - High gain bit doubles reported counts
// - Bits 7:6 select 10/20/40/80 ms interval
// - Offset subtracted from every result
// - Bit 15 enables ambient cancel, 14:13 level
// - Ambient sampled before emitter pulse
// - Ambient deducted from total after pulse
// - Beyond top level enter saturation protection
// - Disabled cancel saturates above 4 klux
// - Saturation forces result to zero
// - Enabled interrupt pulls line low on entry
// - Entry sets the saturation event flag
// - Flag sits at bit 12 of 0xF5
// - Reading flag word clears the flag
module proximity_measure_control
#(
    parameter int INTERVAL_CYC = meas_pkg::INTERVAL_BASE_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [meas_pkg::CMD_W-1:0] cmd,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [meas_pkg::WORD_W-1:0] wdata,
    input wire logic [meas_pkg::COUNT_W-1:0] photo_count,
    input wire logic [meas_pkg::LUX_W-1:0] ambient_klux,
    output logic [meas_pkg::WORD_W-1:0] rdata,
    output logic rvalid,
    output logic emitter_anode_pin,
    output logic int_n
);
    import meas_pkg::*;

    meas_timer_if tm();

    meas_timer #(.INTERVAL_CYC(INTERVAL_CYC)) u_timer
    (
        .clk(clk),
        .rst(rst),
        .tm(tm)
    );

    meas_state_e state_q;
    meas_state_e state_d;
    logic [WORD_W-1:0] config_a_q;
    logic [WORD_W-1:0] config_b_q;
    logic [OFFSET_W-1:0] offset_cancel_value_q;
    logic [COUNT_W-1:0] amb_q;
    logic [GAIN_W-1:0] result_q;
    logic [GAIN_W-1:0] result_d;
    logic sat_q;
    logic flag_q;
    logic flag_d;
    logic int_n_q;
    logic int_n_d;
    logic emit_q;
    logic [WORD_W-1:0] rdata_q;
    logic [WORD_W-1:0] rdata_d;
    logic rvalid_q;

    // Configuration fields
    logic [SEL_W-1:0] pulse_length_sel;
    logic high_gain_bit;
    logic [SEL_W-1:0] meas_interval_sel;
    logic ambient_cancel_enable;
    logic [SEL_W-1:0] ambient_cancel_level;
    logic saturation_irq_enable;
    assign pulse_length_sel = config_a_q[PULSE_SEL_LSB +: SEL_W];
    assign high_gain_bit = config_a_q[HIGH_GAIN_POS];
    assign meas_interval_sel = config_a_q[INTERVAL_LSB +: SEL_W];
    assign ambient_cancel_enable = config_b_q[AMB_EN_POS];
    assign ambient_cancel_level = config_b_q[AMB_LEVEL_LSB +: SEL_W];
    assign saturation_irq_enable = config_b_q[SAT_IRQ_POS];

    // Command decode
    logic wr_cfg_a;
    logic wr_cfg_b;
    logic wr_offset;
    logic rd_flag;
    assign wr_cfg_a = wr_en && (cmd == CMD_CONFIG_A);
    assign wr_cfg_b = wr_en && (cmd == CMD_CONFIG_B);
    assign wr_offset = wr_en && (cmd == CMD_OFFSET);
    assign rd_flag = rd_en && (cmd == CMD_INT_FLAG);

    // Timer controls
    assign tm.pulse_sel = pulse_length_sel;
    assign tm.interval_sel = meas_interval_sel;
    assign tm.start = (state_d == ST_PULSE) && (state_q != ST_PULSE);

    // Sequencer: optional ambient sample, emitter pulse, conversion
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (tm.period_tick)
                    state_d = ambient_cancel_enable ? ST_AMBIENT : ST_PULSE;
            ST_AMBIENT:
                state_d = ST_PULSE;
            ST_PULSE:
                if (tm.pulse_done)
                    state_d = ST_CONVERT;
            ST_CONVERT:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // Result arithmetic
    logic meas_done;
    logic amb_take;
    logic [GAIN_W-1:0] signal_cnt;
    logic [GAIN_W-1:0] gained_cnt;
    logic [GAIN_W-1:0] clean_cnt;
    logic over_lux;
    logic sat_entry;
    assign meas_done = (state_q == ST_CONVERT);
    assign amb_take = (state_q == ST_AMBIENT);
    assign signal_cnt = ambient_cancel_enable
                      ? sat_sub({1'b0, photo_count}, {1'b0, amb_q})
                      : {1'b0, photo_count};
    assign gained_cnt = high_gain_bit ? {signal_cnt[COUNT_W-1:0], 1'b0} : signal_cnt;
    assign clean_cnt = sat_sub(gained_cnt, {1'b0, offset_cancel_value_q});
    assign over_lux = ambient_klux > lux_limit(ambient_cancel_enable,
                                               ambient_cancel_level);
    assign sat_entry = meas_done && over_lux && !sat_q;
    assign result_d = meas_done ? (over_lux ? '0 : clean_cnt) : result_q;

    // Flag and interrupt: a new entry wins over a clearing read
    assign flag_d = sat_entry ? 1'b1 : (rd_flag ? 1'b0 : flag_q);
    assign int_n_d = (sat_entry && saturation_irq_enable) ? 1'b0
                   : (rd_flag ? 1'b1 : int_n_q);

    // Read data mux, reserved bits zero in offset, result and flag words
    always_comb
    begin
        rdata_d = '0;
        case (cmd)
            CMD_CONFIG_A: rdata_d = config_a_q;
            CMD_CONFIG_B: rdata_d = config_b_q;
            CMD_OFFSET: rdata_d = {{(WORD_W-OFFSET_W){1'b0}}, offset_cancel_value_q};
            CMD_RESULT: rdata_d = {{(WORD_W-GAIN_W){1'b0}}, result_q};
            CMD_INT_FLAG: rdata_d[SAT_FLAG_POS] = flag_q;
            default: rdata_d = '0;
        endcase
    end

    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            config_a_q <= CONFIG_A_RST;
            config_b_q <= CONFIG_B_RST;
            offset_cancel_value_q <= OFFSET_RST;
        end
        else
        begin
            if (wr_cfg_a)
                config_a_q <= wdata;
            if (wr_cfg_b)
                config_b_q <= wdata;
            if (wr_offset)
                offset_cancel_value_q <= wdata[OFFSET_W-1:0];
        end
    end

    // Measurement state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            amb_q <= '0;
            result_q <= '0;
            sat_q <= 1'b0;
            emit_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (amb_take)
                amb_q <= photo_count;
            result_q <= result_d;
            if (meas_done)
                sat_q <= over_lux;
            emit_q <= (state_d == ST_PULSE);
        end
    end

    // Flag, interrupt and read port
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flag_q <= 1'b0;
            int_n_q <= 1'b1;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            int_n_q <= int_n_d;
            rvalid_q <= rd_en;
            if (rd_en)
                rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign emitter_anode_pin = emit_q;
    assign int_n = int_n_q;

    // Checking helpers: pulse length and the select in force at its start
    logic [PULSE_CNT_W-1:0] em_cnt_q;
    logic [SEL_W-1:0] em_sel_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            em_cnt_q <= '0;
            em_sel_q <= '0;
        end
        else
        begin
            em_cnt_q <= emit_q ? em_cnt_q + PULSE_CNT_W'(1) : '0;
            if (tm.start)
                em_sel_q <= pulse_length_sel;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    pulse_len_a: assert property ($fell(emit_q) |->
        em_cnt_q == (PULSE_CNT_W'(PULSE_T_CYC) << em_sel_q))
        else $error("emitter pulse length wrong");
    amb_first_a: assert property ($rose(emit_q) && $past(ambient_cancel_enable) |->
        $past(state_q) == ST_AMBIENT)
        else $error("ambient not sampled before pulse");
    gain_even_a: assert property (meas_done && high_gain_bit && !over_lux
        && offset_cancel_value_q == '0 |=> result_q[0] == 1'b0)
        else $error("high gain result not doubled");
    offset_floor_a: assert property (meas_done && !over_lux
        && gained_cnt <= {1'b0, offset_cancel_value_q} |=> result_q == '0)
        else $error("offset subtraction wrapped");
    offset_sub_a: assert property (meas_done && !over_lux && !high_gain_bit
        && !ambient_cancel_enable && photo_count > offset_cancel_value_q
        |=> result_q + {1'b0, $past(offset_cancel_value_q)} == {1'b0, $past(photo_count)})
        else $error("offset not subtracted");
    sat_zero_a: assert property (meas_done && over_lux |=> result_q == '0 && sat_q)
        else $error("saturated result not zero");
    lux_low_a: assert property (meas_done && !ambient_cancel_enable
        && ambient_klux > LUX_NO_CANCEL |=> sat_q)
        else $error("no saturation above base limit");
    flag_set_a: assert property (sat_entry |=> flag_q ##1 (flag_q || $past(rd_flag)))
        else $error("flag not set on entry");
    flag_clr_a: assert property (rd_flag && !sat_entry |=> !flag_q)
        else $error("flag not cleared by read");
    irq_low_a: assert property (sat_entry && saturation_irq_enable |=> !int_n_q)
        else $error("interrupt not driven low");
    irq_quiet_a: assert property (int_n_q && !(sat_entry && saturation_irq_enable)
        |=> int_n_q)
        else $error("interrupt low without cause");
    irq_release_a: assert property (rd_flag && !(sat_entry && saturation_irq_enable)
        |=> int_n_q)
        else $error("interrupt not released by read");
    flag_read_a: assert property (rd_flag
        |=> rdata_q[SAT_FLAG_POS] == $past(flag_q))
        else $error("flag word read wrong");
    amb_hold_a: assert property (amb_take |=> amb_q == $past(photo_count))
        else $error("ambient sample not held");
    amb_sub_a: assert property (meas_done && !over_lux && ambient_cancel_enable
        && !high_gain_bit && offset_cancel_value_q == '0 && photo_count >= amb_q
        |=> result_q == {1'b0, $past(photo_count)} - {1'b0, $past(amb_q)})
        else $error("ambient not deducted");
    emit_state_a: assert property (emit_q == (state_q == ST_PULSE))
        else $error("emitter outside pulse state");

    // Main scenarios reached
    cover_sat_c: cover property (sat_entry ##[1:20] rd_flag);
    cover_amb_c: cover property ((state_q == ST_AMBIENT) ##1 emit_q);
    cover_res_c: cover property (meas_done && !over_lux && clean_cnt != '0);
    cover_gain_c: cover property (meas_done && high_gain_bit && !over_lux);
    cover_mask_c: cover property (sat_entry && !saturation_irq_enable);
endmodule

//--- sensor_model.sv
// Photodiode and ADC front end model for the measurement control.
// Assumes the block samples counts around its emitter pulse on clk.
module sensor_model
(
    input wire logic clk,
    input wire logic emitter_anode_pin,
    input wire logic [11:0] amb_cnt,
    input wire logic [11:0] sig_cnt,
    input wire logic [7:0] klux,
    output logic [11:0] photo_count,
    output logic [7:0] ambient_klux,
    output int width
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold = 0;
    int run = 0;
    // Ambient alone before the pulse, ambient plus reflection during and after it
    assign photo_count = (emitter_anode_pin || hold > 0) ? amb_cnt + sig_cnt : amb_cnt;
    assign ambient_klux = klux;
    // Pulse width measure and short hold of the total after the pulse
    always @(posedge clk)
    begin
        if (emitter_anode_pin)
        begin
            run <= run + 1;
            hold <= 4;
        end
        else
        begin
            if (run > 0)
                width <= run;
            run <= 0;
            if (hold > 0)
                hold <= hold - 1;
        end
    end
endmodule

//--- proximity_measure_control_tb_top.sv
// Self-checking bench of the proximity measurement control.
// Assumes the decoded command port and the front end model.
module proximity_measure_control_tb_top;
    import meas_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int IC = 1000;
    logic clk = 0;
    logic rst = 1;
    logic [7:0] cmd = 0;
    logic wr_en = 0;
    logic rd_en = 0;
    logic [15:0] wdata = 0;
    logic [11:0] amb = 12'h064;
    logic [11:0] sig = 12'h12c;
    logic [7:0] klux = 0;
    logic [11:0] photo_count;
    logic [7:0] ambient_klux;
    logic [15:0] rdata;
    logic rvalid;
    logic emitter;
    logic int_n;
    int width;
    int num_errors = 0;
    int n_compared = 0;
    int lim [5] = '{4, 12, 24, 42, 100};
    time t_rise = 0;
    time t_prev = 0;

    always #50 clk = ~clk;

    proximity_measure_control #(.INTERVAL_CYC(IC)) i_dut (.clk(clk), .rst(rst), .cmd(cmd),
        .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .photo_count(photo_count),
        .ambient_klux(ambient_klux), .rdata(rdata), .rvalid(rvalid),
        .emitter_anode_pin(emitter), .int_n(int_n));
    sensor_model i_sensor (.clk(clk), .emitter_anode_pin(emitter), .amb_cnt(amb),
        .sig_cnt(sig), .klux(klux), .photo_count(photo_count),
        .ambient_klux(ambient_klux), .width(width));

    // Verdict and end of run
    task results;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        #10 cmd = c;
        wdata = d;
        wr_en = 1;
        @(posedge clk);
        #10 wr_en = 0;
    endtask

    // Read answer stands one cycle after the strobe
    task rd(input logic [7:0] c, input logic [15:0] exp);
        @(posedge clk);
        #10 cmd = c;
        rd_en = 1;
        @(posedge clk);
        #10 rd_en = 0;
        chk(16'(rvalid), 16'h0001);
        chk(rdata, exp);
    endtask

    // One full emitter pulse, bounded
    task wait_meas;
        int i;
        i = 0;
        while (emitter !== 1'b1 && i < 40000)
        begin
            @(negedge clk);
            i++;
        end
        t_prev = t_rise;
        t_rise = $time;
        while (emitter !== 1'b0 && i < 40000)
        begin
            @(negedge clk);
            i++;
        end
        repeat (4) @(negedge clk);
        if (i >= 40000)
        begin
            num_errors++;
            $display("ERROR %0t: no measurement", $time);
            results();
        end
    endtask

    task set_klux(input logic [7:0] k);
        @(posedge clk);
        #10 klux = k;
    endtask

    function automatic logic [15:0] exp_res(input int off, input bit en, input bit g,
                                            input bit ov);
        int v;
        v = en ? int'(sig) : int'(sig) + int'(amb);
        v = (g ? 2 : 1) * v - off;
        return (ov || v < 0) ? 16'h0000 : 16'(v);
    endfunction

    task do_case(input logic [15:0] a, input logic [15:0] b, input int off);
        wr(CMD_CONFIG_A, a);
        wr(CMD_CONFIG_B, b);
        wr(CMD_OFFSET, 16'(off));
        wait_meas();
        wait_meas();
        rd(CMD_RESULT, exp_res(off, b[AMB_EN_POS], a[HIGH_GAIN_POS], 0));
    endtask

    initial
    begin
        int k;
        logic [15:0] b;
        repeat (10) @(posedge clk);
        #10 rst = 0;
        // Reset values, unmapped command, offset reserved bits
        rd(CMD_CONFIG_A, CONFIG_A_RST);
        rd(CMD_CONFIG_B, CONFIG_B_RST);
        rd(CMD_OFFSET, 16'(OFFSET_RST));
        rd(CMD_INT_FLAG, 16'h0000);
        wr(8'h20, 16'hffff);
        rd(8'h20, 16'h0000);
        wr(CMD_OFFSET, 16'hf123);
        rd(CMD_OFFSET, 16'h0123);
        wr(CMD_OFFSET, 16'h0000);
        // Pulse length and interval for every code
        for (k = 0; k < 4; k++)
        begin
            wr(CMD_CONFIG_A, 16'((k << PULSE_SEL_LSB) | (k << INTERVAL_LSB)));
            rd(CMD_CONFIG_A, 16'((k << PULSE_SEL_LSB) | (k << INTERVAL_LSB)));
            wait_meas();
            wait_meas();
            wait_meas();
            chk(16'(width), 16'(PULSE_T_CYC << k));
            chk(16'((t_rise - t_prev) / 100), 16'(IC << k));
        end
        // Arithmetic of the result
        do_case(16'h0000, 16'h0000, 0);
        do_case(16'h0000, 16'h8000, 0);
        do_case(16'h0400, 16'h8000, 0);
        do_case(16'h0400, 16'h8000, 50);
        do_case(16'h0400, 16'h8000, 700);
        do_case(16'h0000, 16'h0000, 0);
        // Saturation at and just above each limit, interrupt enabled
        for (k = 0; k < 5; k++)
        begin
            b = (k == 0) ? 16'h0004 : 16'(16'h8004 | ((k - 1) << AMB_LEVEL_LSB));
            set_klux(8'(lim[k]));
            wr(CMD_CONFIG_B, b);
            wait_meas();
            wait_meas();
            rd(CMD_RESULT, exp_res(0, k > 0, 0, 0));
            rd(CMD_INT_FLAG, 16'h0000);
            chk(16'(int_n), 16'h0001);
            set_klux(8'(lim[k] + 1));
            wait_meas();
            chk(16'(int_n), 16'h0000);
            rd(CMD_RESULT, 16'h0000);
            rd(CMD_INT_FLAG, 16'h1000);
            chk(16'(int_n), 16'h0001);
            rd(CMD_INT_FLAG, 16'h0000);
        end
        // Entry with the interrupt masked
        set_klux(8'h00);
        wr(CMD_CONFIG_B, 16'h0000);
        wait_meas();
        set_klux(8'h05);
        wait_meas();
        chk(16'(int_n), 16'h0001);
        rd(CMD_INT_FLAG, 16'h1000);
        results();
    end
endmodule
